// ### oms_pkg.sv
// Package for the operating mode sequencer: modes, timing, carriers.
package oms_pkg;
  localparam int  CLK_HZ             = 40000000;
  localparam int  BOOT_LOW_US        = 100;
  localparam int  BOOT_HIGH_US       = 100;
  localparam int  DEBOUNCE_US        = 100;
  localparam int  BOOT_LOW_CYC       = (BOOT_LOW_US * (CLK_HZ / 1000000));
  localparam int  BOOT_HIGH_CYC      = (BOOT_HIGH_US * (CLK_HZ / 1000000));
  localparam int  DEBOUNCE_CYC       = (DEBOUNCE_US * (CLK_HZ / 1000000));
  localparam int  CNT_W              = 24;
  localparam int  ASLP_W             = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;

  typedef enum logic [2:0] {
    OMS_OFF, OMS_BOOT, OMS_STANDBY, OMS_HIBERNATE, OMS_WAKE, OMS_SLEEP, OMS_TRIG_WAIT
  } oms_mode_t;

  // Host-written control bits
  typedef struct packed {
    logic              active_set;
    logic              active_clr;
    logic              hibernate_set;
    logic              pin_two_function_select;
    logic [ASLP_W-1:0] auto_sleep_count;
  } oms_ctrl_t;

  // Device status
  typedef struct packed {
    oms_mode_t mode;
    logic      active;
    logic      strap_high;
    logic      regs_default;
  } oms_stat_t;
endpackage

// ### oms_pin_sync.sv
// Three-flop pin synchroniser with agreement filter.
`timescale 1ns/100ps
`default_nettype none
module oms_pin_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic s1, s2, s3;
  logic next_level;

  always_comb begin
    next_level = level;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end

  assign rise = next_level & ~level;
  assign fall = ~next_level & level;
endmodule // oms_pin_sync
`default_nettype wire

// ### oms_timer.sv
// Down-counting timer with load and done pulse.
`timescale 1ns/100ps
`default_nettype none
module oms_timer (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     load,
  input  wire logic [oms_pkg::CNT_W-1:0] value,
  input  wire logic                     run,
  output logic                          done
);
  logic [oms_pkg::CNT_W-1:0] cnt;
  logic [oms_pkg::CNT_W-1:0] next_cnt;
  logic                      next_done;

  always_comb begin
    next_cnt  = cnt;
    next_done = 1'b0;
    if (load) begin
      next_cnt = value;
    end else if (run && cnt != oms_pkg::CNT_ZERO) begin
      next_cnt  = cnt - 1'b1;
      next_done = (cnt == {{(oms_pkg::CNT_W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt  <= oms_pkg::CNT_ZERO;
      done <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      done <= next_done;
    end
  end
endmodule // oms_timer
`default_nettype wire

// ### oms_sequencer.sv
// Operating mode sequencer top: boot, standby, hibernate, wake/sleep, trigger wait.
// Contract
// R1: Strap low: boot, then standby awaiting commands.
// R2: Strap high, wire high: auto-set active, wake.
// R3: Strap low: hibernate enable enters hibernate.
// R4: Strap high: wire low debounce enters hibernate.
// R5: Host toggles wake pin to leave hibernate; code honours the toggle only with the strap low.
// R6: Strap high: wire high leaves hibernate, boots; code does so only after wire-low hibernate, not register hibernate.
// R7: Pin-two select enters/leaves trigger wait.
// R8: Strap high: trigger wait unavailable.
// R9: Trigger rising edge starts conversion, wake.
// R10: Measurement done returns to trigger wait.
// R11: Strap low: active bit moves standby/wake.
// R12: Strap high: host may still set active.
// R13: Strap high: debounced low clears active.
// R14: Auto-sleep count reached without event: sleep.
// R15: Sleep returns to wake on event.
// R16: Strap high register hibernate ignores wake pin.
// R17: Hibernate exit restores register defaults.
// R18: Active to standby keeps registers.
// R19: Strap sampled at boot, then held.
// R20: Debounce counter restarts when wire rises.
`timescale 1ns/100ps
`default_nettype none
module oms_sequencer (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              boot_strap_select,
  input  wire logic              wake_pin,
  input  wire logic              motion_wire_pin,
  input  wire logic              trigger_pin,
  input  wire oms_pkg::oms_ctrl_t ctrl,
  input  wire logic              aws_event,
  input  wire logic              measure_done,
  output oms_pkg::oms_stat_t     stat,
  output logic                   conversion_start,
  output logic                   regs_reset
);
  logic wake_rise, wake_fall;
  logic wire_lvl, wire_fall;
  logic trig_rise;
  logic strap_lvl;

  oms_pin_sync u_wake (.clk(clk), .rst(rst), .pin(wake_pin),
    .level(), .rise(wake_rise), .fall(wake_fall));
  oms_pin_sync u_wire (.clk(clk), .rst(rst), .pin(motion_wire_pin),
    .level(wire_lvl), .rise(), .fall(wire_fall));
  oms_pin_sync u_trig (.clk(clk), .rst(rst), .pin(trigger_pin),
    .level(), .rise(trig_rise), .fall());
  oms_pin_sync u_strap (.clk(clk), .rst(rst), .pin(boot_strap_select),
    .level(strap_lvl), .rise(), .fall());

  oms_pkg::oms_mode_t mode, next_mode;
  logic strap_high, next_strap_high;
  logic active, next_active;
  logic reg_hib, next_reg_hib;
  logic conv, next_conv;
  logic rreset, next_rreset;
  logic [oms_pkg::ASLP_W-1:0] aslp, next_aslp;
  logic deb_held, next_deb_held;

  // Boot and debounce timers
  logic boot_load, boot_done, deb_load, deb_done, deb_run;
  logic [oms_pkg::CNT_W-1:0] boot_val;

  assign boot_val = strap_lvl ? oms_pkg::CNT_W'(oms_pkg::BOOT_HIGH_CYC)
                              : oms_pkg::CNT_W'(oms_pkg::BOOT_LOW_CYC);
  assign boot_load = (mode == oms_pkg::OMS_OFF) ||
                     (mode == oms_pkg::OMS_HIBERNATE && next_mode == oms_pkg::OMS_BOOT);

  oms_timer u_boot (.clk(clk), .rst(rst), .load(boot_load), .value(boot_val),
    .run(mode == oms_pkg::OMS_BOOT), .done(boot_done));

  // Debounce restarts whenever the wire is high
  assign deb_load = wire_lvl | wire_fall;                             // see R20
  assign deb_run  = ~wire_lvl & strap_high;
  oms_timer u_deb (.clk(clk), .rst(rst), .load(deb_load),
    .value(oms_pkg::CNT_W'(oms_pkg::DEBOUNCE_CYC)), .run(deb_run), .done(deb_done));

  always_comb begin
    next_mode       = mode;
    next_strap_high = strap_high;
    next_active     = active;
    next_reg_hib    = reg_hib;
    next_conv       = 1'b0;
    next_rreset     = 1'b0;
    next_aslp       = aslp;
    next_deb_held   = deb_held;
    // Expired debounce is held until the wire rises, so hibernate follows standby
    if (deb_done) begin
      next_deb_held = 1'b1;                                           // see R4
    end else if (wire_lvl) begin
      next_deb_held = 1'b0;
    end
    case (mode)
      oms_pkg::OMS_OFF: begin
        next_mode = oms_pkg::OMS_BOOT;
      end
      oms_pkg::OMS_BOOT: begin
        next_strap_high = strap_lvl;                                  // see R19
        if (boot_done) begin
          if (!strap_lvl) begin
            next_mode = oms_pkg::OMS_STANDBY;                         // see R1
          end else if (wire_lvl) begin
            next_active = 1'b1;                                       // see R2
            next_mode   = oms_pkg::OMS_WAKE;
          end else begin
            next_reg_hib = 1'b0;
            next_mode    = oms_pkg::OMS_HIBERNATE;
          end
        end
      end
      oms_pkg::OMS_STANDBY: begin
        // Registers are kept across active to standby
        if (ctrl.hibernate_set) begin
          next_reg_hib = 1'b1;                                        // see R3 R16
          next_mode    = oms_pkg::OMS_HIBERNATE;
        end else if (strap_high && (deb_done || deb_held)) begin
          next_reg_hib = 1'b0;                                        // see R4
          next_mode    = oms_pkg::OMS_HIBERNATE;
        end else if (ctrl.active_set) begin
          next_active = 1'b1;                                         // see R11 R12
          next_mode   = oms_pkg::OMS_WAKE;
        end else if (!strap_high && ctrl.pin_two_function_select) begin
          next_mode = oms_pkg::OMS_TRIG_WAIT;                         // see R7 R8
        end
      end
      oms_pkg::OMS_WAKE, oms_pkg::OMS_SLEEP: begin
        if (strap_high && deb_done) begin
          next_active = 1'b0;                                         // see R13
          next_mode   = oms_pkg::OMS_STANDBY;
        end else if (ctrl.active_clr) begin
          next_active = 1'b0;                                         // see R11 R18
          next_mode   = oms_pkg::OMS_STANDBY;
        end else if (!active && !strap_high && measure_done) begin
          next_mode = oms_pkg::OMS_TRIG_WAIT;                         // see R10
        end else if (mode == oms_pkg::OMS_SLEEP) begin
          if (aws_event) begin
            next_mode = oms_pkg::OMS_WAKE;                            // see R15
            next_aslp = '0;
          end
        end else if (aws_event || ctrl.auto_sleep_count == '0 || !active) begin
          next_aslp = '0;
        end else if (aslp + 1'b1 >= ctrl.auto_sleep_count) begin
          next_mode = oms_pkg::OMS_SLEEP;                             // see R14
          next_aslp = '0;
        end else begin
          next_aslp = aslp + 1'b1;
        end
      end
      oms_pkg::OMS_TRIG_WAIT: begin
        if (strap_high || !ctrl.pin_two_function_select) begin
          next_mode = oms_pkg::OMS_STANDBY;                           // see R7 R8
        end else if (trig_rise) begin
          next_conv = 1'b1;                                           // see R9
          next_mode = oms_pkg::OMS_WAKE;
        end
      end
      oms_pkg::OMS_HIBERNATE: begin
        if (!strap_high && (wake_rise || wake_fall)) begin
          next_mode   = oms_pkg::OMS_BOOT;                            // see R5
          next_rreset = 1'b1;                                         // see R17
          next_active = 1'b0;
          next_aslp   = '0;
        end else if (strap_high && !reg_hib && wire_lvl) begin
          next_mode   = oms_pkg::OMS_BOOT;                            // see R6 R4
          next_rreset = 1'b1;                                         // see R17
          next_active = 1'b0;
          next_aslp   = '0;
        end
      end
      default: next_mode = oms_pkg::OMS_OFF;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode       <= oms_pkg::OMS_OFF;
      strap_high <= 1'b0;
      active     <= 1'b0;
      reg_hib    <= 1'b0;
      conv       <= 1'b0;
      rreset     <= 1'b0;
      aslp       <= '0;
      deb_held   <= 1'b0;
    end else begin
      mode       <= next_mode;
      strap_high <= next_strap_high;
      active     <= next_active;
      reg_hib    <= next_reg_hib;
      conv       <= next_conv;
      rreset     <= next_rreset;
      aslp       <= next_aslp;
      deb_held   <= next_deb_held;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat             <= '0;
      conversion_start <= 1'b0;
      regs_reset       <= 1'b0;
    end else begin
      stat.mode         <= next_mode;
      stat.active       <= next_active;
      stat.strap_high   <= next_strap_high;
      stat.regs_default <= next_rreset;
      conversion_start  <= next_conv;
      regs_reset        <= next_rreset;
    end
  end
endmodule // oms_sequencer
`default_nettype wire

// ### oms_seq_assertions.sv
// Checker for the operating mode sequencer ports.
`timescale 1ns/100ps
`default_nettype none
module oms_seq_assertions (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               boot_strap_select,
  input wire logic               wake_pin,
  input wire logic               motion_wire_pin,
  input wire logic               trigger_pin,
  input wire oms_pkg::oms_ctrl_t ctrl,
  input wire logic               aws_event,
  input wire logic               measure_done,
  input wire oms_pkg::oms_stat_t stat,
  input wire logic               conversion_start,
  input wire logic               regs_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_conv_from_trig: assert property (conversion_start |-> stat.mode == oms_pkg::OMS_WAKE
    && $past(stat.mode) == oms_pkg::OMS_TRIG_WAIT) else $error("bad conversion start");
  a_regs_on_exit: assert property (regs_reset |-> $past(stat.mode) == oms_pkg::OMS_HIBERNATE)
    else $error("register reset outside hibernate exit");
  a_trig_strap_low: assert property (stat.mode == oms_pkg::OMS_TRIG_WAIT |-> !stat.strap_high)
    else $error("trigger wait with strap high");
  a_sleep_needs_cnt: assert property ($past(stat.mode) == oms_pkg::OMS_WAKE
    && stat.mode == oms_pkg::OMS_SLEEP |-> $past(ctrl.auto_sleep_count) != 0)
    else $error("sleep with zero count");
  a_hib_wire_low: assert property ((!motion_wire_pin)[*6] ##0 stat.strap_high
    && stat.mode == oms_pkg::OMS_HIBERNATE |=> stat.mode == oms_pkg::OMS_HIBERNATE)
    else $error("left hibernate with wire low");
  a_hib_pin_still: assert property ($stable(wake_pin)[*6] ##0 !stat.strap_high
    && stat.mode == oms_pkg::OMS_HIBERNATE |=> stat.mode == oms_pkg::OMS_HIBERNATE)
    else $error("left hibernate without wake pin toggle");
  a_boot_standby: assert property ($past(stat.mode) == oms_pkg::OMS_BOOT
    && stat.mode == oms_pkg::OMS_STANDBY |-> !stat.strap_high) else $error("strap high standby");
  a_standby_wake: assert property ($past(stat.mode) == oms_pkg::OMS_STANDBY
    && stat.mode == oms_pkg::OMS_WAKE |-> stat.active) else $error("wake without active");
endmodule // oms_seq_assertions
bind oms_sequencer oms_seq_assertions chk (.clk(clk), .rst(rst),
  .boot_strap_select(boot_strap_select), .wake_pin(wake_pin), .motion_wire_pin(motion_wire_pin),
  .trigger_pin(trigger_pin), .ctrl(ctrl), .aws_event(aws_event), .measure_done(measure_done),
  .stat(stat), .conversion_start(conversion_start), .regs_reset(regs_reset));
`default_nettype wire

// ### oms_host_model.sv
// Host model driving the wake and trigger pins.
`timescale 1ns/100ps
`default_nettype none
module oms_host_model (
  input  wire logic clk,
  input  wire logic toggle_req,
  input  wire logic trig_req,
  output var logic  wake_pin = 1'b1,
  output var logic  trigger_pin = 1'b0
);
  // Requests change at the falling edge, so they are taken at the rising one
  always_ff @(posedge clk) begin
    if (toggle_req) begin
      wake_pin <= ~wake_pin;
    end
    trigger_pin <= trig_req;
  end
endmodule // oms_host_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the operating mode sequencer, both strap levels.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk, rst, strap, motion, aws_event, measure_done, toggle_req, trig_req;
  logic wake_pin, trigger_pin, conversion_start, regs_reset;
  oms_pkg::oms_ctrl_t ctrl;
  oms_pkg::oms_stat_t stat;
  int err_count, checked, n;
  oms_sequencer dut (.clk(clk), .rst(rst), .boot_strap_select(strap), .wake_pin(wake_pin),
    .motion_wire_pin(motion), .trigger_pin(trigger_pin), .ctrl(ctrl), .aws_event(aws_event),
    .measure_done(measure_done), .stat(stat), .conversion_start(conversion_start),
    .regs_reset(regs_reset));
  oms_host_model host (.clk(clk), .toggle_req(toggle_req), .trig_req(trig_req),
    .wake_pin(wake_pin), .trigger_pin(trigger_pin));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d, checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Counts falling edges until the mode shows; gives up after lim
  task automatic wait_mode(input oms_pkg::oms_mode_t m, input int lim);
    n = 0;
    checked++;
    while (stat.mode !== m) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        err_count++;
        $display("Error at %0t: mode %0d not reached", $time, m);
        tally_and_finish;
      end
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic t_boot;
    wait_mode(oms_pkg::OMS_STANDBY, 45000);
    check(n + 2 >= oms_pkg::BOOT_LOW_CYC, 1);
    check(stat.strap_high, 0);
  endtask
  task automatic t_active;
    ctrl.active_set = 1'b1;
    step(1);
    ctrl.active_set = 1'b0;
    wait_mode(oms_pkg::OMS_WAKE, 4);
    check(stat.active, 1);
    ctrl.active_clr = 1'b1;
    step(1);
    ctrl.active_clr = 1'b0;
    wait_mode(oms_pkg::OMS_STANDBY, 4);
    check(stat.active, 0);
  endtask
  task automatic t_trig;
    ctrl.pin_two_function_select = 1'b1;
    wait_mode(oms_pkg::OMS_TRIG_WAIT, 4);
    trig_req = 1'b1;
    wait_mode(oms_pkg::OMS_WAKE, 10);
    check(conversion_start, 1);
    measure_done = 1'b1;
    step(1);
    measure_done = 1'b0;
    trig_req = 1'b0;
    wait_mode(oms_pkg::OMS_TRIG_WAIT, 4);
    ctrl.pin_two_function_select = 1'b0;
    wait_mode(oms_pkg::OMS_STANDBY, 4);
  endtask
  task automatic t_aslp;
    ctrl.active_set = 1'b1;
    step(1);
    ctrl.active_set = 1'b0;
    step(40);
    check(stat.mode, oms_pkg::OMS_WAKE);
    ctrl.auto_sleep_count = 16'h0010;
    aws_event = 1'b1;
    step(1);
    aws_event = 1'b0;
    wait_mode(oms_pkg::OMS_SLEEP, 40);
    check(n >= 15, 1);
    aws_event = 1'b1;
    step(1);
    aws_event = 1'b0;
    wait_mode(oms_pkg::OMS_WAKE, 4);
    ctrl.auto_sleep_count = 16'h0000;
    ctrl.active_clr = 1'b1;
    step(1);
    ctrl.active_clr = 1'b0;
    wait_mode(oms_pkg::OMS_STANDBY, 4);
  endtask
  task automatic t_hib;
    ctrl.hibernate_set = 1'b1;
    step(1);
    ctrl.hibernate_set = 1'b0;
    wait_mode(oms_pkg::OMS_HIBERNATE, 4);
    step(20);
    check(stat.mode, oms_pkg::OMS_HIBERNATE);
    toggle_req = 1'b1;
    step(1);
    toggle_req = 1'b0;
    wait_mode(oms_pkg::OMS_BOOT, 10);
    check(regs_reset, 1);
    check(stat.regs_default, 1);
    wait_mode(oms_pkg::OMS_STANDBY, 45000);
  endtask
  // Second reset with the strap high: wire-driven hibernate and wake
  task automatic t_strap;
    rst = 1'b1;
    strap = 1'b1;
    step(4);
    rst = 1'b0;
    wait_mode(oms_pkg::OMS_WAKE, 4500);
    check(stat.active, 1);
    check(stat.strap_high, 1);
    motion = 1'b0;
    wait_mode(oms_pkg::OMS_STANDBY, 4100);
    check(n >= oms_pkg::DEBOUNCE_CYC, 1);
    check(stat.active, 0);
    wait_mode(oms_pkg::OMS_HIBERNATE, 4);
    step(20);
    check(stat.mode, oms_pkg::OMS_HIBERNATE);
    motion = 1'b1;
    wait_mode(oms_pkg::OMS_BOOT, 10);
    check(regs_reset, 1);
    wait_mode(oms_pkg::OMS_WAKE, 4500);
    ctrl.active_clr = 1'b1;
    step(1);
    ctrl.active_clr = 1'b0;
    wait_mode(oms_pkg::OMS_STANDBY, 4);
    ctrl.active_set = 1'b1;
    step(1);
    ctrl.active_set = 1'b0;
    wait_mode(oms_pkg::OMS_WAKE, 4);
    check(stat.active, 1);
    ctrl.active_clr = 1'b1;
    step(1);
    ctrl.active_clr = 1'b0;
    wait_mode(oms_pkg::OMS_STANDBY, 4);
    ctrl.hibernate_set = 1'b1;
    step(1);
    ctrl.hibernate_set = 1'b0;
    wait_mode(oms_pkg::OMS_HIBERNATE, 4);
    toggle_req = 1'b1;
    step(1);
    toggle_req = 1'b0;
    step(20);
    check(stat.mode, oms_pkg::OMS_HIBERNATE);
  endtask
  initial begin
    rst = 1'b1;
    strap = 1'b0;
    motion = 1'b1;
    aws_event = 1'b0;
    measure_done = 1'b0;
    toggle_req = 1'b0;
    trig_req = 1'b0;
    ctrl = '0;
    err_count = 0;
    checked = 0;
    step(16);
    rst = 1'b0;
    t_boot;
    t_active;
    t_trig;
    t_aslp;
    t_hib;
    t_strap;
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
